// File: include/hpsm_regs.svh
// register offsets, field positions, reset values and timing counts for the schedule maps
`ifndef HPSM_REGS_SVH
`define HPSM_REGS_SVH
`define HPSM_OFF_PERIODIC_FINAL 8'hae
`define HPSM_OFF_ASYNC_DONE 8'hb0
`define HPSM_OFF_ASYNC_BYPASS 8'hb2
`define HPSM_OFF_ASYNC_FINAL 8'hb4
`define HPSM_OFF_HW_MODE 8'hb6
`define HPSM_RST_FINAL 16'h0000
`define HPSM_RST_DONE 16'h0000
`define HPSM_RST_BYPASS 16'hffff
`define HPSM_RST_HW_MODE 16'h0000
`define HPSM_HW_MODE_MASK 16'h1e7f
`define HPSM_BIT_ID_SAMPLER 12
`define HPSM_BIT_PERIPH_DMA 11
`define HPSM_BIT_SHARED_IRQ 10
`define HPSM_BIT_SHARED_DMA 9
`define HPSM_BIT_ACK_POL 6
`define HPSM_BIT_REQ_POL 5
`define HPSM_BIT_BUS_WIDTH 4
`define HPSM_BIT_IF_LOCK 3
`define HPSM_BIT_IRQ_POL 2
`define HPSM_BIT_IRQ_TRIG 1
`define HPSM_BIT_IRQ_EN 0
`define HPSM_BYPASS_SETTLE_NS 100
`define HPSM_CLK_PERIOD_NS 4
`define HPSM_BYPASS_SETTLE_CYC ((`HPSM_BYPASS_SETTLE_NS + `HPSM_CLK_PERIOD_NS - 1) / `HPSM_CLK_PERIOD_NS)
`endif

// File: include/hpsm_pkg.sv
// types shared by the schedule map logic
package hpsm_pkg;
  typedef logic [15:0] hpsm_map_t;
  typedef logic [3:0] hpsm_idx_t;
  typedef enum logic [2:0] {
    HPSM_IDLE = 3'b001,
    HPSM_SCAN = 3'b010,
    HPSM_BUSY = 3'b100
  } hpsm_state_e;
endpackage

// File: include/hpsm_scan_if.sv
// scanner hookup between the register bank and one category scanner
interface hpsm_scan_if;
  logic [15:0] final_map;
  logic [15:0] bypass_map;
  logic [15:0] valid_map;
  logic enable;
  logic issue;
  logic [3:0] issue_idx;
  logic [3:0] cur_idx;
  logic busy;
  modport bank (output final_map, output bypass_map, output valid_map, output enable,
    input issue, input issue_idx, input cur_idx, input busy);
  modport scan (input final_map, input bypass_map, input valid_map, input enable,
    output issue, output issue_idx, output cur_idx, output busy);
endinterface

// File: rtl/hpsm_scanner.sv
// round-robin descriptor scanner for one transfer category
`include "hpsm_regs.svh"
module hpsm_scanner
  import hpsm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_exec_done,
  hpsm_scan_if.scan sif
);
  hpsm_state_e state_r, state_nxt;
  hpsm_idx_t idx_r, idx_nxt;
  logic issue_nxt;
  logic wrap;
  logic take;

  ////////////////////////////////////////////////////////////////////////
  // scan control
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    issue_nxt = 1'b0;
    // final flag ends the pass; no flag means all 16 are scanned
    wrap = sif.final_map[idx_r] || (idx_r == 4'hf);
    // bypass bit hides a descriptor even when it is valid
    take = sif.valid_map[idx_r] && !sif.bypass_map[idx_r];
    case (state_r)
      HPSM_IDLE: begin
        idx_nxt = 4'h0;
        if (sif.enable) begin
          state_nxt = HPSM_SCAN;
        end
      end
      HPSM_SCAN: begin
        if (!sif.enable) begin
          state_nxt = HPSM_IDLE;
        end else if (take) begin
          issue_nxt = 1'b1;
          state_nxt = HPSM_BUSY;
        end else begin
          idx_nxt = wrap ? 4'h0 : idx_r + 4'h1;
        end
      end
      HPSM_BUSY: begin
        if (i_exec_done) begin
          state_nxt = HPSM_SCAN;
          idx_nxt = wrap ? 4'h0 : idx_r + 4'h1;
        end
      end
      default: state_nxt = HPSM_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= HPSM_IDLE;
      idx_r <= 4'h0;
      sif.issue <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      sif.issue <= issue_nxt;
    end
  end

  assign sif.issue_idx = idx_r;
  assign sif.cur_idx = idx_r;
  assign sif.busy = (state_r == HPSM_BUSY);

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_final_seen;
    (state_r == HPSM_SCAN) && sif.enable && !take && sif.final_map[idx_r];
  endsequence
  chk_wrap_on_final: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_final_seen |=> idx_r == 4'h0) else $error("scan did not wrap after final descriptor");
  chk_bypass_never_issued: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sif.issue |-> !sif.bypass_map[sif.issue_idx]) else $error("bypassed descriptor issued");
  chk_full_scan: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_r == HPSM_SCAN) && sif.enable && !take && sif.final_map == 16'h0000
    && idx_r != 4'hf |=> idx_r == $past(idx_r) + 4'h1)
    else $error("scan skipped ahead without final flag");
endmodule // hpsm_scanner

// File: rtl/hpsm_bank.sv
// schedule map register bank: final, completion and bypass maps plus hardware mode
// Operation
// - a final-flag bit marks the last descriptor examined in its category
// - after the final descriptor, scanning resumes from descriptor zero
// - periodic final map: 16-bit read/write, resets to zero
// - async final map: 16-bit read/write, one-hot, resets to zero; the code stores any written pattern, zero included
// - async completion map: 16-bit read-only, one bit per descriptor, resets zero
// - a completing descriptor sets its completion bit at once
// - reading a completion map clears the whole map; a completion in the same cycle still sets its bit
// - async bypass map: 16-bit read/write, resets to all ones
// - a bypassed descriptor is never processed even when valid
// - hardware mode register: 16-bit read/write, resets zero, fixed field positions
// - with master enable clear the interrupt output is never asserted
// - bus width bit: zero selects 16-bit bus, one selects 8-bit
// - trigger bit: zero level output, one a pulse of set width
`include "hpsm_regs.svh"
module hpsm_bank
  import hpsm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0] i_byte_en,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_async_valid,
  input wire logic i_async_exec_done,
  input wire logic i_irq_event,
  input wire logic [7:0] i_irq_pulse_clks,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_async_issue,
  output logic [3:0] o_async_issue_idx,
  output logic [15:0] o_periodic_final_map,
  output logic [15:0] o_hw_mode,
  output logic o_bus_8bit,
  output logic o_irq
);
  hpsm_map_t periodic_final_r, periodic_final_nxt;
  hpsm_map_t async_final_r, async_final_nxt;
  hpsm_map_t async_bypass_r, async_bypass_nxt;
  hpsm_map_t async_done_r, async_done_nxt;
  hpsm_map_t hw_mode_r, hw_mode_nxt;
  logic [15:0] rdata_nxt;
  logic rvalid_nxt;
  logic [7:0] pulse_cnt_r, pulse_cnt_nxt;
  logic irq_evt_d_r;
  logic irq_r, irq_nxt;
  logic async_issue_r;
  logic [3:0] async_idx_r;
  logic [3:0] done_idx;
  hpsm_scan_if sif();

  // byte-lane merge so single-byte writes in 8-bit mode update only one lane
  function automatic hpsm_map_t merge(input hpsm_map_t old_v, input logic [15:0] new_v,
                                      input logic [1:0] be);
    merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic hpsm_map_t onehot(input logic [3:0] idx);
    onehot = 16'h0001 << idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_comb begin
    periodic_final_nxt = periodic_final_r;
    async_final_nxt = async_final_r;
    async_bypass_nxt = async_bypass_r;
    hw_mode_nxt = hw_mode_r;
    async_done_nxt = async_done_r;
    rdata_nxt = 16'h0000;
    rvalid_nxt = 1'b0;
    if (i_wr) begin
      if (i_addr == `HPSM_OFF_PERIODIC_FINAL) begin
        periodic_final_nxt = merge(periodic_final_r, i_wdata, i_byte_en);
      end else if (i_addr == `HPSM_OFF_ASYNC_FINAL) begin
        async_final_nxt = merge(async_final_r, i_wdata, i_byte_en);
      end else if (i_addr == `HPSM_OFF_ASYNC_BYPASS) begin
        async_bypass_nxt = merge(async_bypass_r, i_wdata, i_byte_en);
      end else if (i_addr == `HPSM_OFF_HW_MODE) begin
        hw_mode_nxt = merge(hw_mode_r, i_wdata, i_byte_en);
      end
    end
    if (i_rd) begin
      rvalid_nxt = 1'b1;
      if (i_addr == `HPSM_OFF_PERIODIC_FINAL) begin
        rdata_nxt = periodic_final_r;
      end else if (i_addr == `HPSM_OFF_ASYNC_DONE) begin
        rdata_nxt = async_done_r;
        async_done_nxt = 16'h0000;
      end else if (i_addr == `HPSM_OFF_ASYNC_BYPASS) begin
        rdata_nxt = async_bypass_r;
      end else if (i_addr == `HPSM_OFF_ASYNC_FINAL) begin
        rdata_nxt = async_final_r;
      end else if (i_addr == `HPSM_OFF_HW_MODE) begin
        rdata_nxt = hw_mode_r;
      end
    end
    // completion set wins over the read clear
    if (i_async_exec_done) begin
      async_done_nxt = async_done_nxt | onehot(done_idx);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      periodic_final_r <= `HPSM_RST_FINAL;
      async_final_r <= `HPSM_RST_FINAL;
      async_bypass_r <= `HPSM_RST_BYPASS;
      async_done_r <= `HPSM_RST_DONE;
      hw_mode_r <= `HPSM_RST_HW_MODE;
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      periodic_final_r <= periodic_final_nxt;
      async_final_r <= async_final_nxt;
      async_bypass_r <= async_bypass_nxt;
      async_done_r <= async_done_nxt;
      hw_mode_r <= hw_mode_nxt;
      o_rdata <= rdata_nxt;
      o_rvalid <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // async list scanner
  assign sif.final_map = async_final_r;
  assign sif.bypass_map = async_bypass_r;
  assign sif.valid_map = i_async_valid;
  assign sif.enable = 1'b1;
  assign done_idx = sif.cur_idx;

  hpsm_scanner u_async_scan (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_exec_done(i_async_exec_done),
    .sif(sif)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      async_issue_r <= 1'b0;
      async_idx_r <= 4'h0;
    end else begin
      async_issue_r <= sif.issue;
      async_idx_r <= sif.issue_idx;
    end
  end
  assign o_async_issue = async_issue_r;
  assign o_async_issue_idx = async_idx_r;
  assign o_periodic_final_map = periodic_final_r;
  assign o_hw_mode = hw_mode_r;
  assign o_bus_8bit = hw_mode_r[`HPSM_BIT_BUS_WIDTH];

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin shaping
  logic irq_active;
  always_comb begin
    pulse_cnt_nxt = pulse_cnt_r;
    irq_active = 1'b0;
    if (!hw_mode_r[`HPSM_BIT_IRQ_EN]) begin
      pulse_cnt_nxt = 8'h00;
    end else if (!hw_mode_r[`HPSM_BIT_IRQ_TRIG]) begin
      irq_active = i_irq_event;
      pulse_cnt_nxt = 8'h00;
    end else begin
      // a zero width setting still gives a one-cycle pulse
      if (i_irq_event && !irq_evt_d_r) begin
        pulse_cnt_nxt = (i_irq_pulse_clks == 8'h00) ? 8'h01 : i_irq_pulse_clks;
      end else if (pulse_cnt_r != 8'h00) begin
        pulse_cnt_nxt = pulse_cnt_r - 8'h01;
      end
      irq_active = (pulse_cnt_nxt != 8'h00);
    end
    // polarity applied last so the idle level is right from reset
    irq_nxt = hw_mode_r[`HPSM_BIT_IRQ_POL] ? irq_active : !irq_active;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pulse_cnt_r <= 8'h00;
      irq_evt_d_r <= 1'b0;
      irq_r <= 1'b1;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
      irq_evt_d_r <= i_irq_event;
      irq_r <= irq_nxt;
    end
  end
  assign o_irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_irq_gated_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(hw_mode_r[`HPSM_BIT_IRQ_EN]) |-> o_irq == !$past(hw_mode_r[`HPSM_BIT_IRQ_POL]))
    else $error("interrupt asserted while disabled");
  chk_done_read_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_rd && i_addr == `HPSM_OFF_ASYNC_DONE && !i_async_exec_done |=> async_done_r == 16'h0000
    && o_rdata == $past(async_done_r)) else $error("completion map not cleared on read");
  chk_done_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_async_exec_done |=> async_done_r[$past(done_idx)]) else $error("completion bit lost");
  chk_bypass_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_ASYNC_BYPASS && i_byte_en == 2'b11
    |=> async_bypass_r == $past(i_wdata)) else $error("bypass map write lost");
  chk_mode_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_rd && !i_wr && i_addr == `HPSM_OFF_HW_MODE |=> o_rvalid && o_rdata == $past(hw_mode_r))
    else $error("mode readback wrong");
  chk_level_irq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    hw_mode_r == 16'h0005 && $stable(hw_mode_r) |=> o_irq == $past(i_irq_event))
    else $error("level interrupt not following event");

  ////////////////////////////////////////////////////////////////////////
  // register map and pin shaping checks
  sequence s_done_read;
    i_rd && i_addr == `HPSM_OFF_ASYNC_DONE;
  endsequence
  sequence s_edge_rise;
    hw_mode_r[2:0] == 3'b111 && i_irq_event && !irq_evt_d_r;
  endsequence
  chk_reset_values: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(i_rst)
    |-> periodic_final_r == `HPSM_RST_FINAL && async_final_r == `HPSM_RST_FINAL
    && async_done_r == `HPSM_RST_DONE && async_bypass_r == `HPSM_RST_BYPASS
    && hw_mode_r == `HPSM_RST_HW_MODE)
    else $error("register not at reset value");
  chk_periodic_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_PERIODIC_FINAL && i_byte_en == 2'b11
    |=> periodic_final_r == $past(i_wdata))
    else $error("periodic final map write lost");
  chk_periodic_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_rd && !i_wr && i_addr == `HPSM_OFF_PERIODIC_FINAL
    |=> o_rvalid && o_rdata == $past(periodic_final_r))
    else $error("periodic final map readback wrong");
  chk_final_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_ASYNC_FINAL && i_byte_en == 2'b11
    |=> async_final_r == $past(i_wdata))
    else $error("async final map write lost");
  chk_final_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_rd && !i_wr && i_addr == `HPSM_OFF_ASYNC_FINAL
    |=> o_rvalid && o_rdata == $past(async_final_r))
    else $error("async final map readback wrong");
  chk_bypass_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_rd && !i_wr && i_addr == `HPSM_OFF_ASYNC_BYPASS
    |=> o_rvalid && o_rdata == $past(async_bypass_r))
    else $error("bypass map readback wrong");
  chk_bypass_lane: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_ASYNC_BYPASS && i_byte_en == 2'b10
    |=> ((async_bypass_r ^ $past(async_bypass_r)) & 16'h00ff) == 16'h0000
    && ((async_bypass_r ^ $past(i_wdata)) & 16'hff00) == 16'h0000)
    else $error("bypass map lane merge wrong");
  chk_done_stable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(i_rd && i_addr == `HPSM_OFF_ASYNC_DONE) && !i_async_exec_done
    |=> $stable(async_done_r))
    else $error("completion map changed without event or read");
  chk_done_new_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_done_read ##0 i_async_exec_done
    |=> $onehot(async_done_r) && async_done_r[$past(done_idx)])
    else $error("completion bit lost across read clear");
  chk_mode_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_HW_MODE && i_byte_en == 2'b11
    |=> hw_mode_r == $past(i_wdata))
    else $error("mode write lost");
  chk_mode_lane: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_HW_MODE && i_byte_en == 2'b01
    |=> ((hw_mode_r ^ $past(hw_mode_r)) & 16'hff00) == 16'h0000
    && ((hw_mode_r ^ $past(i_wdata)) & 16'h00ff) == 16'h0000)
    else $error("mode lane merge wrong");
  chk_bus_narrow: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_HW_MODE && i_byte_en[0] && i_wdata[`HPSM_BIT_BUS_WIDTH]
    |=> o_bus_8bit)
    else $error("bus width not narrowed");
  chk_bus_wide: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_wr && i_addr == `HPSM_OFF_HW_MODE && i_byte_en[0] && !i_wdata[`HPSM_BIT_BUS_WIDTH]
    |=> !o_bus_8bit)
    else $error("bus width not widened");
  chk_level_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    hw_mode_r[2:0] == 3'b001
    |=> o_irq == !$past(i_irq_event))
    else $error("active low level interrupt wrong");
  chk_edge_start: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_edge_rise
    |=> o_irq)
    else $error("edge interrupt did not start");
  chk_edge_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_edge_rise ##0 i_irq_pulse_clks != 8'h00
    |=> pulse_cnt_r == $past(i_irq_pulse_clks))
    else $error("edge pulse width not loaded");
  chk_edge_count: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    hw_mode_r[1:0] == 2'b11 && !(i_irq_event && !irq_evt_d_r) && pulse_cnt_r != 8'h00
    |=> pulse_cnt_r == $past(pulse_cnt_r) - 8'h01)
    else $error("edge pulse count did not step down");
  chk_edge_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    hw_mode_r[2:0] == 3'b111 && !(i_irq_event && !irq_evt_d_r) && pulse_cnt_r <= 8'h01
    |=> !o_irq)
    else $error("edge interrupt held too long");
  chk_issue_not_bypassed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_async_issue
    |-> !async_bypass_r[o_async_issue_idx])
    else $error("bypassed descriptor sent to execution");
  chk_read_answer: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_rd
    |=> o_rvalid)
    else $error("read strobe got no answer");
  chk_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_rvalid
    |-> o_rdata == 16'h0000)
    else $error("read data not zero outside answer");
endmodule // hpsm_bank

// File: tb/hpsm_exec_model.sv
// descriptor execution engine model: finishes each issued descriptor after a fixed delay
module hpsm_exec_model #(
  parameter int LAT = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_issue,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // one descriptor in flight at a time, as the scanner expects
  always @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    if (i_rst) begin
      cnt <= 0;
    end else if (i_issue) begin
      cnt <= LAT;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // hpsm_exec_model

// File: tb/test_hpsm_bank.sv
// register and scheduling tests for the schedule map bank
module test_hpsm_bank;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ev = 1'b0, done;
  logic [7:0] addr = 8'h00, pclks = 8'h03;
  logic [15:0] wd = 16'h0000, valid = 16'hffff, rdata, pmap, hw, seen;
  logic [1:0] be = 2'h3;
  logic rvalid, issue, b8, irq;
  logic seen_clr = 1'b1;
  logic [3:0] idx;
  int failures = 0, total_checks = 0, n0 = 0, hi;
  always #2 clk = ~clk;
  hpsm_bank uut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wd), .i_byte_en(be),
    .i_wr(wr), .i_rd(rd), .i_async_valid(valid), .i_async_exec_done(done),
    .i_irq_event(ev), .i_irq_pulse_clks(pclks), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_async_issue(issue), .o_async_issue_idx(idx), .o_periodic_final_map(pmap),
    .o_hw_mode(hw), .o_bus_8bit(b8), .o_irq(irq));
  hpsm_exec_model #(.LAT(5)) model (.i_clk_sys(clk), .i_rst(rst), .i_issue(issue),
    .o_done(done));
  always @(posedge clk) begin
    if (seen_clr) begin
      seen <= 16'h0000;
    end else if (issue === 1'b1) begin
      seen[idx] <= 1'b1;
    end
    if (issue === 1'b1 && idx === 4'h0) n0 <= n0 + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    @(negedge clk);
    addr = a;
    wd = d;
    be = b;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // read data stands one cycle only, so it is sampled at the next falling edge
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk1("rvalid", 1'b1, rvalid);
    chk16($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    seen_clr = 1'b0;
    chk1("irq idle", 1'b1, irq);
    rreg(8'hae, 16'h0000);
    rreg(8'hb0, 16'h0000);
    rreg(8'hb2, 16'hffff);
    rreg(8'hb4, 16'h0000);
    rreg(8'hb6, 16'h0000);
    rreg(8'h00, 16'h0000);
    cyc(40);
    chk16("seen all bypassed", 16'h0000, seen);
    wreg(8'hae, 16'h0003, 2'h3);
    chk16("periodic out", 16'h0003, pmap);
    rreg(8'hae, 16'h0003);
    wreg(8'hb0, 16'hffff, 2'h3);
    rreg(8'hb0, 16'h0000);
    // final flag on descriptor 2: descriptor 3 must never be reached
    wreg(8'hb4, 16'h0004, 2'h3);
    rreg(8'hb4, 16'h0004);
    wreg(8'hb2, 16'hfff0, 2'h3);
    cyc(25);
    rreg(8'hb2, 16'hfff0);
    cyc(200);
    valid = 16'h0000;
    cyc(20);
    chk16("seen final", 16'h0007, seen);
    chk1("wrapped", 1'b1, n0 > 2);
    rreg(8'hb0, 16'h0007);
    rreg(8'hb0, 16'h0000);
    seen_clr = 1'b1;
    cyc(1);
    seen_clr = 1'b0;
    wreg(8'hb4, 16'h0000, 2'h3);
    wreg(8'hb2, 16'h7ffe, 2'h3);
    valid = 16'hffff;
    cyc(200);
    valid = 16'h0000;
    cyc(20);
    chk16("seen full", 16'h8001, seen);
    rreg(8'hb0, 16'h8001);
    // mode register lanes, bus width and interrupt pin
    wreg(8'hb6, 16'h0010, 2'h3);
    chk1("bus 8bit", 1'b1, b8);
    wreg(8'hb6, 16'hff05, 2'h1);
    chk16("mode lane", 16'h0005, hw);
    chk1("bus 16bit", 1'b0, b8);
    rreg(8'hb6, 16'h0005);
    ev = 1'b1;
    cyc(3);
    chk1("irq high", 1'b1, irq);
    ev = 1'b0;
    cyc(3);
    chk1("irq high idle", 1'b0, irq);
    wreg(8'hb6, 16'h0001, 2'h3);
    ev = 1'b1;
    cyc(3);
    chk1("irq low", 1'b0, irq);
    wreg(8'hb6, 16'h0000, 2'h3);
    cyc(3);
    chk1("irq masked", 1'b1, irq);
    ev = 1'b0;
    wreg(8'hb6, 16'h0007, 2'h3);
    cyc(3);
    ev = 1'b1;
    hi = 0;
    repeat (12) begin
      @(negedge clk);
      if (irq === 1'b1) hi++;
    end
    chk1("edge width", 1'b1, hi == 3);
    ev = 1'b0;
    report_and_stop();
  end
endmodule // test_hpsm_bank
